// >>> testbench/i2c_host_model.sv
/* Serial-bus host model: drives the bus clock and pulls the data line low.
   Assumes the bench resolves the data wire open-drain with a pull-up. */
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hp(input int n);
        repeat (n) @(negedge clk);
    endtask
    // also serves as repeated start; ten clocks keep each phase above eight
    task automatic start();
        hp(3);
        sda_low = 1'b0;
        hp(10);
        scl = 1'b1;
        hp(10);
        sda_low = 1'b1;
        hp(10);
        scl = 1'b0;
    endtask
    task automatic stop();
        hp(3);
        sda_low = 1'b1;
        hp(10);
        scl = 1'b1;
        hp(10);
        sda_low = 1'b0;
        hp(10);
    endtask
    // data moves 3 clk after the clock fall, so no false start is seen
    task automatic bit_io(input logic b, output logic r);
        hp(3);
        sda_low = !b;
        hp(10);
        scl = 1'b1;
        hp(10);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic tx(input logic [7:0] b, output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], nak);
        bit_io(1'b1, nak);
    endtask
    // one byte per read, always closed with a nack
    task automatic rx(output logic [7:0] b);
        logic k;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(1'b1, k);
    endtask
endmodule

// >>> testbench/tb_flicker_cfg_regs.sv
/* Bench for the flicker and pad config bank: register access via the host
   model, channel samples from the bench. Assumes a short modulator period. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_flicker_cfg_regs;
    localparam logic [6:0] ADDR = 7'h2a;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic chan_valid = 1'b0;
    logic [5:0][15:0] smp = '0;
    logic scl, sda_low, sda_o, sda_oe, sda_load_high, chan_ready, flicker_active;
    logic frequency_extractor_enable, first_general_pin_o, first_general_pin_oe;
    logic first_pin_analog_en, second_general_pin_o, second_general_pin_oe;
    logic [2:0] data_line_drive_strength;
    logic [7:0] ra [4] = '{8'h31, 8'h32, 8'h3c, 8'h41};
    logic [7:0] rv [4] = '{8'h00, 8'h05, 8'h09, 8'h00};
    logic [7:0] rm [4] = '{8'h5f, 8'h07, 8'h0f, 8'h03};
    int n_errors = 0;
    int n_checks = 0;
    int c, ix;
    wire sda = !sda_low && !(sda_oe && !sda_o);
    always #25 clk = ~clk;
    i2c_host_model host (.clk, .sda, .scl, .sda_low);
    flicker_cfg_regs #(.PDM_PERIOD(2), .DEV_ADDR(ADDR)) dut (.clk, .reset_n,
        .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .data_line_drive_strength,
        .sda_load_high, .chan_sample(smp), .chan_valid, .chan_ready,
        .frequency_extractor_enable, .flicker_active, .first_general_pin_o,
        .first_general_pin_oe, .first_pin_analog_en, .second_general_pin_o,
        .second_general_pin_oe);
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k0, k1, k2;
        host.start();
        host.tx({ADDR, 1'b0}, k0);
        host.tx(a, k1);
        host.tx(d, k2);
        host.stop();
        `CHK({k0, k1, k2}, 3'h0)
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic k0, k1, k2;
        logic [7:0] d;
        host.start();
        host.tx({ADDR, 1'b0}, k0);
        host.tx(a, k1);
        host.start();
        host.tx({ADDR, 1'b1}, k2);
        host.rx(d);
        host.stop();
        `CHK({k0, k1, k2, d}, {3'h0, e})
    endtask
    task automatic ones(output int n);
        n = 0;
        repeat (32) begin
            @(negedge clk);
            if (second_general_pin_o === 1'b1)
                n++;
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHK({sda_load_high, data_line_drive_strength}, 4'h9)
        `CHK({frequency_extractor_enable, flicker_active}, 2'h0)
        for (int i = 0; i < 4; i++) begin
            rc(ra[i], rv[i]);
            wr(ra[i], 8'hff);
            rc(ra[i], rm[i]);
        end
        // channel code 111 stays inactive, drive code 7 clamps to the top step
        `CHK({frequency_extractor_enable, flicker_active}, 2'h2)
        `CHK(data_line_drive_strength, 3'h4)
        rc(8'h33, 8'h00);
        for (int s = 0; s < 5; s++) begin
            wr(8'h3c, 8'(s));
            `CHK({sda_load_high, data_line_drive_strength}, 4'(s))
        end
        wr(8'h32, 8'h03);
        wr(8'h31, 8'h46);
        chan_valid = 1'b1;
        // full-scale channel 2 holds the bitstream high, so open drain lets go
        smp[1] = 16'hffff;
        for (int t = 0; t < 4; t++) begin
            wr(8'h41, 8'(t));
            `CHK({first_pin_analog_en, first_general_pin_oe}, {t == 2, t == 1})
            `CHK(first_general_pin_o, t == 1)
            `CHK(second_general_pin_oe, 1'b0)
        end
        for (int code = 1; code < 7; code++) begin
            ix = (code == 1) ? 5 : code - 2;
            wr(8'h31, 8'h50 | 8'(code << 1));
            for (int ph = 0; ph < 2; ph++) begin
                smp = ph ? '1 : '0;
                smp[ix] = ph ? 16'h0 : 16'hffff;
                repeat (40) @(negedge clk);
                ones(c);
                `CHK({flicker_active, second_general_pin_oe}, 2'h3)
                `CHK(ph ? c <= 4 : c >= 28, 1'b1)
            end
        end
        // channel 6 with the offset level applied
        smp = '0;
        wr(8'h31, 8'h12);
        `CHK({flicker_active, second_general_pin_oe}, 2'h3)
        for (c = 0; c < 100 && chan_ready; c++)
            @(negedge clk);
        `CHK(chan_ready, 1'b0)
        chan_valid = 1'b0;
        for (c = 0; c < 100 && !chan_ready; c++)
            @(negedge clk);
        `CHK(chan_ready, 1'b1)
        end_sim();
    end
endmodule

// >>> verilog/fifo_buf.sv
/*
 * Flop-based FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH a power of two, at least 2.
 */
`timescale 1ns/1ps
module fifo_buf #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    stream_if.sink in_s,
    stream_if.source out_s
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("fifo_buf depth must be a power of two");
        end
    endgenerate

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;

    wire push = in_s.valid && in_s.ready;
    wire pop = out_s.valid && out_s.ready;

    assign in_s.ready = count_q != (PW+1)'(DEPTH);
    assign out_s.valid = count_q != '0;
    assign out_s.data = mem_q[rd_ptr_q];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end

    // storage carries no reset; words are only read once written
    always_ff @(posedge clk) begin
        if (push)
            mem_q[wr_ptr_q] <= in_s.data;
    end
endmodule

// >>> verilog/flicker_cfg_pkg.sv
/*
 * Constants for the flicker path and pad configuration register bank:
 * register offsets, reset values, writable-bit masks, field positions,
 * channel and pin-type encodings, default sizes.
 * Assumes registers are byte wide and addressed over the serial bus.
 */
package flicker_cfg_pkg;
    localparam logic [7:0] REG_FLICKER_CTRL = 8'h31;
    localparam logic [7:0] REG_PEDESTAL = 8'h32;
    localparam logic [7:0] REG_PAD_DRIVE = 8'h3c;
    localparam logic [7:0] REG_PIN_TYPE = 8'h41;

    localparam logic [7:0] RST_FLICKER_CTRL = 8'h00;
    localparam logic [7:0] RST_PEDESTAL = 8'h05;
    localparam logic [7:0] RST_PAD_DRIVE = 8'h09;
    localparam logic [7:0] RST_PIN_TYPE = 8'h00;

    localparam logic [7:0] MASK_FLICKER_CTRL = 8'h5f;
    localparam logic [7:0] MASK_PEDESTAL = 8'h07;
    localparam logic [7:0] MASK_PAD_DRIVE = 8'h0f;
    localparam logic [7:0] MASK_PIN_TYPE = 8'h03;

    localparam int EXTRACT_BIT = 0;
    localparam int CHAN_LSB = 1;
    localparam int CHAN_W = 3;
    localparam int PIN_SEL_BIT = 4;
    localparam int PED_DIS_BIT = 6;
    localparam int PED_W = 3;
    localparam int PAD_LOAD_BIT = 3;
    localparam int DRIVE_W = 3;
    localparam int PIN_TYPE_W = 2;

    localparam logic [2:0] CHAN_NONE = 3'h0;
    localparam logic [2:0] CHAN_6 = 3'h1;
    localparam logic [2:0] CHAN_1 = 3'h2;
    localparam logic [2:0] CHAN_5 = 3'h6;
    localparam logic [2:0] CH6_INDEX = 3'h5;
    localparam logic [2:0] DRIVE_MAX = 3'h4;

    localparam logic [1:0] PIN_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] PIN_PUSH_PULL = 2'h1;
    localparam logic [1:0] PIN_ANALOG = 2'h2;

    localparam int NUM_CHANNELS = 6;
    localparam int SAMPLE_W_DEFAULT = 16;
    localparam int FIFO_DEPTH_DEFAULT = 8;
    localparam int PDM_PERIOD_DEFAULT = 16;
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2a;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // code 001 is channel 6, 010..110 are channels 1..5
    function automatic logic [2:0] chan_index(input logic [2:0] code);
        if (code == CHAN_6)
            chan_index = CH6_INDEX;
        else if (code >= CHAN_1 && code <= CHAN_5)
            chan_index = code - CHAN_1;
        else
            chan_index = 3'h0;
    endfunction

    function automatic logic chan_active(input logic [2:0] code);
        chan_active = (code >= CHAN_6) && (code <= CHAN_5);
    endfunction
endpackage

// >>> verilog/flicker_cfg_regs.sv
/*
 * Flicker path and pad configuration register bank with its serial-bus
 * target, the channel selector, offset adder, buffer and PDM modulator.
 * Assumes the bus pins are asynchronous and the channel samples come
 * from logic on clk.
 */
`timescale 1ns/1ps
module flicker_cfg_regs #(
    parameter int SAMPLE_W = flicker_cfg_pkg::SAMPLE_W_DEFAULT,
    parameter int FIFO_DEPTH = flicker_cfg_pkg::FIFO_DEPTH_DEFAULT,
    parameter int PDM_PERIOD = flicker_cfg_pkg::PDM_PERIOD_DEFAULT,
    parameter logic [6:0] DEV_ADDR = flicker_cfg_pkg::BUS_ADDR_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [2:0] data_line_drive_strength,
    output logic sda_load_high,
    input wire logic [flicker_cfg_pkg::NUM_CHANNELS-1:0][SAMPLE_W-1:0] chan_sample,
    input wire logic chan_valid,
    output logic chan_ready,
    output logic frequency_extractor_enable,
    output logic flicker_active,
    output logic first_general_pin_o,
    output logic first_general_pin_oe,
    output logic first_pin_analog_en,
    output logic second_general_pin_o,
    output logic second_general_pin_oe
);
    generate
        if (SAMPLE_W < flicker_cfg_pkg::PED_W + 1 || PDM_PERIOD < 1 || PDM_PERIOD > 65535)
        begin : g_bad_param
            $error("flicker_cfg_regs parameter out of range");
        end
    endgenerate
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WRITE, BUS_WRITE_ACK, BUS_READ, BUS_READ_ACK
    } bus_state_t;
    logic [1:0] line_s;
    logic scl_q, sda_q;
    bus_state_t state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
    logic have_ptr_q, have_ptr_d, is_read_q, is_read_d;
    logic master_ack_q, master_ack_d, sda_oe_q, sda_oe_d, wr_commit;
    logic [7:0] flicker_ctrl_q, pedestal_q, pad_drive_q, pin_type_q;

    sync2 #(.WIDTH(2)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({scl_i, sda_i}),
        .q(line_s)
    );
    wire scl_s = line_s[1];
    wire sda_s = line_s[0];
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_seen = scl_s && scl_q && sda_q && !sda_s;
    wire stop_seen = scl_s && scl_q && !sda_q && sda_s;

    // unmapped offsets read as zero
    wire [7:0] rd_data = (ptr_q == flicker_cfg_pkg::REG_FLICKER_CTRL) ? flicker_ctrl_q :
                         (ptr_q == flicker_cfg_pkg::REG_PEDESTAL) ? pedestal_q :
                         (ptr_q == flicker_cfg_pkg::REG_PAD_DRIVE) ? pad_drive_q :
                         (ptr_q == flicker_cfg_pkg::REG_PIN_TYPE) ? pin_type_q : 8'h00;
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        have_ptr_d = have_ptr_q;
        is_read_d = is_read_q;
        master_ack_d = master_ack_q;
        sda_oe_d = sda_oe_q;
        wr_commit = 1'b0;
        if (start_seen) begin
            state_d = BUS_ADDR;
            bit_cnt_d = 4'h0;
            have_ptr_d = 1'b0;
            sda_oe_d = 1'b0;
        end else if (stop_seen) begin
            state_d = BUS_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                BUS_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                BUS_ADDR, BUS_WRITE: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == flicker_cfg_pkg::BYTE_BITS) begin
                        bit_cnt_d = 4'h0;
                        if (state_q == BUS_ADDR) begin
                            state_d = (shift_q[7:1] == DEV_ADDR) ? BUS_ADDR_ACK : BUS_IDLE;
                            sda_oe_d = shift_q[7:1] == DEV_ADDR;
                            is_read_d = shift_q[0];
                        end else begin
                            state_d = BUS_WRITE_ACK;
                            sda_oe_d = 1'b1;
                            if (have_ptr_q) begin
                                wr_commit = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end else begin
                                ptr_d = shift_q;
                                have_ptr_d = 1'b1;
                            end
                        end
                    end
                end
                BUS_ADDR_ACK, BUS_WRITE_ACK: begin
                    if (scl_fall && state_q == BUS_ADDR_ACK && is_read_q) begin
                        state_d = BUS_READ;
                        shift_d = rd_data;
                        ptr_d = ptr_q + 8'h01;
                        sda_oe_d = !rd_data[7];
                    end else if (scl_fall) begin
                        state_d = BUS_WRITE;
                        sda_oe_d = 1'b0;
                    end
                end
                BUS_READ: begin
                    if (scl_fall && bit_cnt_q == flicker_cfg_pkg::LAST_TX_BIT) begin
                        state_d = BUS_READ_ACK;
                        bit_cnt_d = 4'h0;
                        sda_oe_d = 1'b0;
                    end else if (scl_fall) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        shift_d = {shift_q[6:0], 1'b0};
                        sda_oe_d = !shift_q[6];
                    end
                end
                BUS_READ_ACK: begin
                    if (scl_rise) begin
                        master_ack_d = !sda_s;
                    end else if (scl_fall && master_ack_q) begin
                        state_d = BUS_READ;
                        shift_d = rd_data;
                        ptr_d = ptr_q + 8'h01;
                        sda_oe_d = !rd_data[7];
                    end else if (scl_fall) begin
                        state_d = BUS_IDLE;
                    end
                end
                default: state_d = BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {scl_q, sda_q} <= 2'h3;
            state_q <= BUS_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            {have_ptr_q, is_read_q, master_ack_q, sda_oe_q} <= 4'h0;
        end else begin
            {scl_q, sda_q} <= line_s;
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            {have_ptr_q, is_read_q, master_ack_q, sda_oe_q} <=
                {have_ptr_d, is_read_d, master_ack_d, sda_oe_d};
        end
    end

    // open-drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;

    wire wr_ctrl = wr_commit && ptr_q == flicker_cfg_pkg::REG_FLICKER_CTRL;
    wire wr_ped = wr_commit && ptr_q == flicker_cfg_pkg::REG_PEDESTAL;
    wire wr_pad = wr_commit && ptr_q == flicker_cfg_pkg::REG_PAD_DRIVE;
    wire wr_pin = wr_commit && ptr_q == flicker_cfg_pkg::REG_PIN_TYPE;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flicker_ctrl_q <= flicker_cfg_pkg::RST_FLICKER_CTRL;
            pedestal_q <= flicker_cfg_pkg::RST_PEDESTAL;
            pad_drive_q <= flicker_cfg_pkg::RST_PAD_DRIVE;
            pin_type_q <= flicker_cfg_pkg::RST_PIN_TYPE;
        end else begin
            if (wr_ctrl)
                flicker_ctrl_q <= shift_q & flicker_cfg_pkg::MASK_FLICKER_CTRL;
            if (wr_ped)
                pedestal_q <= shift_q & flicker_cfg_pkg::MASK_PEDESTAL;
            if (wr_pad)
                pad_drive_q <= shift_q & flicker_cfg_pkg::MASK_PAD_DRIVE;
            if (wr_pin)
                pin_type_q <= shift_q & flicker_cfg_pkg::MASK_PIN_TYPE;
        end
    end

    wire [2:0] chan_code = flicker_ctrl_q[flicker_cfg_pkg::CHAN_LSB +: flicker_cfg_pkg::CHAN_W];
    wire [2:0] chan_idx = flicker_cfg_pkg::chan_index(chan_code);
    wire path_on = flicker_cfg_pkg::chan_active(chan_code);
    wire flicker_pin_select = flicker_ctrl_q[flicker_cfg_pkg::PIN_SEL_BIT];
    wire offset_level_disable = flicker_ctrl_q[flicker_cfg_pkg::PED_DIS_BIT];
    wire [2:0] offset_level_value = pedestal_q[flicker_cfg_pkg::PED_W-1:0];
    wire [1:0] first_pin_output_type = pin_type_q[flicker_cfg_pkg::PIN_TYPE_W-1:0];
    wire [2:0] drive_raw = pad_drive_q[flicker_cfg_pkg::DRIVE_W-1:0];

    assign frequency_extractor_enable = flicker_ctrl_q[flicker_cfg_pkg::EXTRACT_BIT];
    assign flicker_active = path_on;
    assign sda_load_high = pad_drive_q[flicker_cfg_pkg::PAD_LOAD_BIT];
    // codes above the fifth step are not defined; hold the pad at the top step
    assign data_line_drive_strength = (drive_raw > flicker_cfg_pkg::DRIVE_MAX) ?
                                      flicker_cfg_pkg::DRIVE_MAX : drive_raw;

    // offset only added while offset_level_disable is clear
    wire [SAMPLE_W-1:0] sel_sample = chan_sample[chan_idx];
    wire [SAMPLE_W-1:0] ped_ext = offset_level_disable ? '0 :
                        {{(SAMPLE_W-flicker_cfg_pkg::PED_W){1'b0}}, offset_level_value};
    wire [SAMPLE_W:0] ped_sum = {1'b0, sel_sample} + {1'b0, ped_ext};

    stream_if #(.W(SAMPLE_W)) wr_if ();
    stream_if #(.W(SAMPLE_W)) rd_if ();
    assign wr_if.valid = chan_valid && path_on;
    assign wr_if.data = ped_sum[SAMPLE_W] ? '1 : ped_sum[SAMPLE_W-1:0];
    assign chan_ready = wr_if.ready;
    fifo_buf #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_s(wr_if),
        .out_s(rd_if)
    );
    // modulator takes one word per period; the source stalls when it falls behind
    logic [15:0] period_q;
    logic [SAMPLE_W-1:0] cur_word_q, acc_q;
    logic pdm_q;
    wire slot = period_q == 16'h0000;
    wire [SAMPLE_W:0] acc_sum = {1'b0, acc_q} + {1'b0, cur_word_q};
    assign rd_if.ready = path_on && slot;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_q <= 16'h0000;
            cur_word_q <= '0;
            acc_q <= '0;
            pdm_q <= 1'b0;
        end else if (!path_on) begin
            period_q <= 16'h0000;
            cur_word_q <= '0;
            acc_q <= '0;
            pdm_q <= 1'b0;
        end else begin
            period_q <= slot ? 16'(PDM_PERIOD - 1) : period_q - 16'h0001;
            if (rd_if.valid && rd_if.ready)
                cur_word_q <= rd_if.data;
            acc_q <= acc_sum[SAMPLE_W-1:0];
            pdm_q <= acc_sum[SAMPLE_W];
        end
    end

    wire on_first = path_on && !flicker_pin_select;
    wire is_od = first_pin_output_type == flicker_cfg_pkg::PIN_OPEN_DRAIN;
    wire is_pp = first_pin_output_type == flicker_cfg_pkg::PIN_PUSH_PULL;
    wire is_an = first_pin_output_type == flicker_cfg_pkg::PIN_ANALOG;

    assign first_general_pin_o = is_pp && pdm_q;
    assign first_general_pin_oe = on_first && ((is_od && !pdm_q) || is_pp);
    assign first_pin_analog_en = on_first && is_an;
    assign second_general_pin_o = pdm_q;
    assign second_general_pin_oe = path_on && flicker_pin_select;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_no_channel_no_push;
        (chan_code == flicker_cfg_pkg::CHAN_NONE) |-> !wr_if.valid && !flicker_active;
    endproperty
    a_no_channel_no_push: assert property (p_no_channel_no_push)
        else $error("push with no channel selected");
    property p_ch6_route;
        (wr_if.valid && chan_code == flicker_cfg_pkg::CHAN_6 && offset_level_disable)
            |-> wr_if.data == chan_sample[flicker_cfg_pkg::CH6_INDEX];
    endproperty
    a_ch6_route: assert property (p_ch6_route)
        else $error("channel 6 not routed");
    property p_extractor_write;
        wr_ctrl |=> frequency_extractor_enable == $past(shift_q[flicker_cfg_pkg::EXTRACT_BIT]);
    endproperty
    a_extractor_write: assert property (p_extractor_write)
        else $error("extractor enable does not follow write");
    property p_pin_select;
        (flicker_active && flicker_pin_select) |-> !first_general_pin_oe && !first_pin_analog_en
            && second_general_pin_oe;
    endproperty
    a_pin_select: assert property (p_pin_select)
        else $error("bitstream on wrong pin");
    property p_offset_applied;
        (wr_if.valid && !offset_level_disable && offset_level_value != 3'h0
            && chan_code == flicker_cfg_pkg::CHAN_6 && !(&chan_sample[flicker_cfg_pkg::CH6_INDEX]))
            |-> wr_if.data != chan_sample[flicker_cfg_pkg::CH6_INDEX];
    endproperty
    a_offset_applied: assert property (p_offset_applied)
        else $error("offset level not applied");
    property p_pedestal_write;
        wr_ped |=> offset_level_value == $past(shift_q[2:0]) ##1 $stable(offset_level_value);
    endproperty
    a_pedestal_write: assert property (p_pedestal_write)
        else $error("offset level write lost");
    property p_load_write;
        wr_pad |=> sda_load_high == $past(shift_q[flicker_cfg_pkg::PAD_LOAD_BIT]);
    endproperty
    a_load_write: assert property (p_load_write)
        else $error("load class does not follow write");
    property p_drive_write;
        (wr_pad && shift_q[2:0] <= flicker_cfg_pkg::DRIVE_MAX)
            |=> data_line_drive_strength == $past(shift_q[2:0]);
    endproperty
    a_drive_write: assert property (p_drive_write)
        else $error("drive strength does not follow write");
    property p_open_drain;
        (is_od && on_first) |-> !first_general_pin_o && (first_general_pin_oe == !pdm_q);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin drives high");
    property p_push_pull;
        (is_pp && on_first) |-> first_general_pin_oe && first_general_pin_o == pdm_q;
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull pin not driven");
    property p_reserved_zero;
        wr_ctrl |=> (flicker_ctrl_q & ~flicker_cfg_pkg::MASK_FLICKER_CTRL) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit stored");
    c_ctrl_write: cover property (wr_ctrl && shift_q[flicker_cfg_pkg::EXTRACT_BIT]);
    c_read_byte: cover property (state_q == BUS_READ_ACK && scl_fall);
    c_fifo_full: cover property (wr_if.valid && !wr_if.ready);
    c_pdm_high: cover property (pdm_q && flicker_active);
endmodule

// >>> verilog/stream_if.sv
/*
 * Valid/ready word stream between the flicker path and its buffer.
 * Assumes both ends share one clock; a word moves when valid and ready.
 */
`timescale 1ns/1ps
interface stream_if #(
    parameter int W = 16
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport sink (input valid, input data, output ready);
    modport source (output valid, output data, input ready);
endinterface

// >>> verilog/sync2.sv
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes inputs are levels; only the second stage is for use.
 */
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '1;
            q <= '1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
